/* core/psc_pkg.sv */
// constants and types for the phy system control register bank
package psc_pkg;
    // management addressing
    localparam logic [4:0] PSC_DEVAD = 5'h1e;
    localparam logic [4:0] PSC_GROUP_PRTAD = 5'h1f;
    // register offsets inside the vendor device
    localparam logic [15:0] PSC_OFS_PHY_RST = 16'h8814;
    localparam logic [15:0] PSC_OFS_MAC_RST = 16'h8815;
    localparam logic [15:0] PSC_OFS_STAT = 16'h8818;
    localparam logic [15:0] PSC_OFS_PMG = 16'h8819;
    localparam logic [15:0] PSC_OFS_DIAG = 16'h882c;
    localparam logic [15:0] PSC_OFS_PKG = 16'h8c22;
    localparam logic [15:0] PSC_OFS_MDIO = 16'h8c30;
    localparam logic [15:0] PSC_OFS_PINMUX = 16'h8c56;
    // reset values
    localparam logic [15:0] PSC_RST_ADDR = 16'h0000;
    localparam logic [15:0] PSC_RST_DIAG_RSVD = 16'h0002;
    localparam logic [7:0] PSC_RST_PINMUX = 8'hfe;
    // field positions and widths
    localparam int PSC_POS_CTRL = 0;
    localparam int PSC_POS_SYS_RDY = 0;
    localparam int PSC_POS_PD_RDY = 1;
    localparam int PSC_POS_POL = 0;
    localparam int PSC_POS_LED1 = 1;
    localparam int PSC_POS_CAPT = 4;
    localparam int PSC_POS_TIMER = 6;
    localparam int PSC_PKG_W = 6;
    // timestamp timer routing codes
    localparam logic [1:0] PSC_TM_RXD1 = 2'h0;
    localparam logic [1:0] PSC_TM_LED0 = 2'h1;
    localparam logic [1:0] PSC_TM_INT = 2'h2;
    localparam logic [1:0] PSC_TM_NONE = 2'h3;
    // timestamp capture source codes
    localparam logic [1:0] PSC_CP_TXD1 = 2'h0;
    localparam logic [1:0] PSC_CP_LED1 = 2'h1;
    localparam logic [1:0] PSC_CP_MDIO = 2'h2;
    // second led pin function codes
    localparam logic [2:0] PSC_L1_LED = 3'h0;
    localparam logic [2:0] PSC_L1_TXER = 3'h1;
    localparam logic [2:0] PSC_L1_TXEN = 3'h2;
    localparam logic [2:0] PSC_L1_TXCLK = 3'h3;
    localparam logic [2:0] PSC_L1_TXD0 = 3'h4;
    localparam logic [2:0] PSC_L1_TXD2 = 3'h5;
    localparam logic [2:0] PSC_L1_LINK = 3'h6;
    localparam logic [2:0] PSC_L1_OFF = 3'h7;

    typedef enum logic [1:0] {PSC_OP_ADDR, PSC_OP_WRITE, PSC_OP_READ, PSC_OP_READ_INC} psc_op_e;

    typedef struct packed {
        psc_op_e op;
        logic [4:0] prtad;
        logic [4:0] devad;
        logic [15:0] data;
    } psc_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } psc_rsp_s;
endpackage : psc_pkg

/* core/psc_regs.sv */
// phy system control register bank with pin multiplexer
// What this block does
// (R01) Writing one to phy reset bit starts subsystem reset; clears when done.
// (R02) Writing one to interface reset bit starts interface reset; clears when done.
// (R03) Status bit 1 reads one while in software power-down.
// (R04) Status bit 0 reads one once start-up completes.
// (R05) Boot oscillator force bit forces clock on; resets to zero.
// (R06) Diagnostics clock enable bit enables that clock; resets to zero.
// (R07) Package register low six bits report the package type.
// (R08) Group mode accepts writes and address operations sent to port 31.
// (R09) Host sets group mode only during multiport init, clears it right after.
// (R10) Timer mux routes timestamp timer to rxd1, first led, interrupt or nowhere.
// (R11) Capture mux takes capture input from txd1, second led, mdio or nothing.
// (R12) Second led pin mux selects one of eight functions, last disables it.
// (R13) Link status polarity zero drives active high, one active low.
// (R14) All registers answer on vendor device 0x1E, also during power-down.
// (R15) Reserved bits read reset values; reset bits read one while active.
`timescale 1ns/100ps
`default_nettype none

module psc_regs
    import psc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management access
    input wire logic req_valid,
    input wire psc_req_s req,
    input wire logic [4:0] my_prtad,
    output var psc_rsp_s rsp,
    // system state
    input wire logic sys_ready_in,
    input wire logic power_down_in,
    input wire logic phy_rst_done,
    input wire logic mac_rst_done,
    input wire logic [PSC_PKG_W-1:0] pkg_type,
    // control outputs
    output logic phy_rst_req,
    output logic mac_rst_req,
    output logic boot_osc_force,
    output logic diag_clk_on,
    output logic group_addr_mode,
    // pin functions inside the device
    input wire logic timestamp_timer_out_src,
    input wire logic rxd1_func,
    input wire logic led0_func,
    input wire logic int_func,
    input wire logic led1_func,
    input wire logic tx_er,
    input wire logic tx_en,
    input wire logic tx_clk,
    input wire logic txd0,
    input wire logic txd2,
    input wire logic link_up,
    // output pins
    output logic rxd1_o,
    output logic first_led_pin,
    output logic int_o,
    output logic second_led_pin,
    output logic second_led_oe_n,
    output logic link_status_out,
    // capture pins
    input wire logic txd1_pin,
    input wire logic second_led_in,
    input wire logic mdio_in,
    output logic timestamp_capture_in,
    output logic capture_assigned
);

    // self-clearing reset bit: a new request wins over completion
    function automatic logic sc_next(input logic cur, input logic set, input logic done);
        sc_next = set | (cur & ~done);
    endfunction : sc_next

    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic phy_rst_reg;
    logic mac_rst_reg;
    logic osc_reg;
    logic diag_reg;
    logic grp_reg;
    logic [7:0] pinmux_reg;
    psc_rsp_s rsp_reg;
    psc_rsp_s rsp_next;
    logic [2:0] cap_meta_reg;
    logic [2:0] cap_sync_reg;
    logic rxd1_reg;
    logic led0_reg;
    logic int_reg;
    logic led1_reg;
    logic led1_oe_n_reg;
    logic link_reg;
    logic capt_reg;
    logic capt_on_reg;

    // access decode
    wire dev_ok = (req.devad == PSC_DEVAD); // R14
    wire own_port = (req.prtad == my_prtad);
    wire grp_port = grp_reg && (req.prtad == PSC_GROUP_PRTAD);
    wire wr_port_ok = own_port || grp_port; // R08
    wire is_wr = (req.op == PSC_OP_WRITE);
    wire is_adr = (req.op == PSC_OP_ADDR);
    wire is_rd = (req.op == PSC_OP_READ) || (req.op == PSC_OP_READ_INC);
    wire wr_hit = req_valid && dev_ok && wr_port_ok && is_wr;
    wire adr_hit = req_valid && dev_ok && wr_port_ok && is_adr; // R08
    wire rd_hit = req_valid && dev_ok && own_port && is_rd;
    wire inc_hit = rd_hit && (req.op == PSC_OP_READ_INC);
    wire wbit = req.data[PSC_POS_CTRL];

    wire wr_phy = wr_hit && (addr_reg == PSC_OFS_PHY_RST);
    wire wr_mac = wr_hit && (addr_reg == PSC_OFS_MAC_RST);
    wire wr_pmg = wr_hit && (addr_reg == PSC_OFS_PMG);
    wire wr_diag = wr_hit && (addr_reg == PSC_OFS_DIAG);
    wire wr_mdio = wr_hit && (addr_reg == PSC_OFS_MDIO);
    wire wr_pin = wr_hit && (addr_reg == PSC_OFS_PINMUX);
    wire phy_set = wr_phy && wbit;
    wire mac_set = wr_mac && wbit;

    // mux fields
    wire pol = pinmux_reg[PSC_POS_POL];
    wire [2:0] led1_sel = pinmux_reg[PSC_POS_LED1 +: 3];
    wire [1:0] capt_sel = pinmux_reg[PSC_POS_CAPT +: 2];
    wire [1:0] tm_sel = pinmux_reg[PSC_POS_TIMER +: 2];
    wire link_lvl = link_up ^ pol; // R13

    // address register, post-read increment
    always_comb begin
        addr_next = addr_reg;
        if (adr_hit) begin
            addr_next = req.data;
        end else if (inc_hit) begin
            addr_next = addr_reg + 16'h0001;
        end
    end

    // read data selection
    always_comb begin
        rsp_next.valid = rd_hit;
        rsp_next.data = 16'h0000;
        if (!rd_hit) begin
            rsp_next.data = 16'h0000;
        end else if (addr_reg == PSC_OFS_PHY_RST) begin
            rsp_next.data = {15'h0000, phy_rst_reg}; // R15
        end else if (addr_reg == PSC_OFS_MAC_RST) begin
            rsp_next.data = {15'h0000, mac_rst_reg}; // R15
        end else if (addr_reg == PSC_OFS_STAT) begin
            rsp_next.data = {14'h0000, power_down_in, sys_ready_in}; // R03 R04
        end else if (addr_reg == PSC_OFS_PMG) begin
            rsp_next.data = {15'h0000, osc_reg};
        end else if (addr_reg == PSC_OFS_DIAG) begin
            rsp_next.data = PSC_RST_DIAG_RSVD | {15'h0000, diag_reg}; // R15
        end else if (addr_reg == PSC_OFS_PKG) begin
            rsp_next.data = {10'h000, pkg_type}; // R07
        end else if (addr_reg == PSC_OFS_MDIO) begin
            rsp_next.data = {15'h0000, grp_reg};
        end else if (addr_reg == PSC_OFS_PINMUX) begin
            rsp_next.data = {8'h00, pinmux_reg};
        end
    end

    // register updates
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_reg <= PSC_RST_ADDR;
            phy_rst_reg <= 1'b0;
            mac_rst_reg <= 1'b0;
            osc_reg <= 1'b0;
            diag_reg <= 1'b0;
            grp_reg <= 1'b0;
            pinmux_reg <= PSC_RST_PINMUX;
            rsp_reg <= '0;
        end else begin
            addr_reg <= addr_next;
            phy_rst_reg <= sc_next(phy_rst_reg, phy_set, phy_rst_done); // R01
            mac_rst_reg <= sc_next(mac_rst_reg, mac_set, mac_rst_done); // R02
            osc_reg <= wr_pmg ? wbit : osc_reg; // R05
            diag_reg <= wr_diag ? wbit : diag_reg; // R06
            grp_reg <= wr_mdio ? wbit : grp_reg; // R08
            pinmux_reg <= wr_pin ? req.data[7:0] : pinmux_reg;
            rsp_reg <= rsp_next; // R14
        end
    end

    // capture pins cross in through two flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_meta_reg <= 3'h0;
            cap_sync_reg <= 3'h0;
        end else begin
            cap_meta_reg <= {mdio_in, second_led_in, txd1_pin};
            cap_sync_reg <= cap_meta_reg;
        end
    end

    // second led pin source
    logic led1_next;
    always_comb begin
        case (led1_sel)
            PSC_L1_LED: led1_next = led1_func;
            PSC_L1_TXER: led1_next = tx_er;
            PSC_L1_TXEN: led1_next = tx_en;
            PSC_L1_TXCLK: led1_next = tx_clk;
            PSC_L1_TXD0: led1_next = txd0;
            PSC_L1_TXD2: led1_next = txd2;
            PSC_L1_LINK: led1_next = link_lvl;
            default: led1_next = 1'b0;
        endcase
    end

    // capture source
    logic capt_next;
    always_comb begin
        case (capt_sel)
            PSC_CP_TXD1: capt_next = cap_sync_reg[0];
            PSC_CP_LED1: capt_next = cap_sync_reg[1];
            PSC_CP_MDIO: capt_next = cap_sync_reg[2];
            default: capt_next = 1'b0;
        endcase
    end

    // led pin is released when disabled or used as capture input
    wire led1_off = (led1_sel == PSC_L1_OFF) || (capt_sel == PSC_CP_LED1);

    // pin outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            rxd1_reg <= 1'b0;
            led0_reg <= 1'b0;
            int_reg <= 1'b0;
            led1_reg <= 1'b0;
            led1_oe_n_reg <= 1'b1;
            link_reg <= 1'b0;
            capt_reg <= 1'b0;
            capt_on_reg <= 1'b0;
        end else begin
            rxd1_reg <= (tm_sel == PSC_TM_RXD1) ? timestamp_timer_out_src : rxd1_func; // R10
            led0_reg <= (tm_sel == PSC_TM_LED0) ? timestamp_timer_out_src : led0_func; // R10
            int_reg <= (tm_sel == PSC_TM_INT) ? timestamp_timer_out_src : int_func; // R10
            led1_reg <= led1_next; // R12
            led1_oe_n_reg <= led1_off; // R12
            link_reg <= link_lvl; // R13
            capt_reg <= capt_next; // R11
            capt_on_reg <= (capt_sel != PSC_TM_NONE); // R11
        end
    end

    assign rsp = rsp_reg;
    assign phy_rst_req = phy_rst_reg;
    assign mac_rst_req = mac_rst_reg;
    assign boot_osc_force = osc_reg;
    assign diag_clk_on = diag_reg;
    assign group_addr_mode = grp_reg;
    assign rxd1_o = rxd1_reg;
    assign first_led_pin = led0_reg;
    assign int_o = int_reg;
    assign second_led_pin = led1_reg;
    assign second_led_oe_n = led1_oe_n_reg;
    assign link_status_out = link_reg;
    assign timestamp_capture_in = capt_reg;
    assign capture_assigned = capt_on_reg;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_phy_kick;
        phy_set;
    endsequence

    sequence s_mac_kick;
        mac_set;
    endsequence

    sequence s_stat_read;
        rd_hit && (addr_reg == PSC_OFS_STAT);
    endsequence

    a_phy_rst_start: assert property (s_phy_kick |=> phy_rst_req) // R01
        else $error("phy reset bit not set by write");
    a_phy_rst_clear: assert property (
        phy_rst_req && phy_rst_done && !phy_set |=> !phy_rst_req) // R01
        else $error("phy reset bit not self cleared");
    a_mac_rst_start: assert property (s_mac_kick |=> mac_rst_req ##0 rsp_reg.valid == 1'b0) // R02
        else $error("interface reset bit not set by write");
    a_mac_rst_clear: assert property (
        mac_rst_req && !mac_rst_done && !mac_set |=> mac_rst_req) // R02
        else $error("interface reset bit dropped early");
    a_stat_read: assert property (s_stat_read |=>
        rsp.valid && rsp.data == {14'h0000, $past(power_down_in), $past(sys_ready_in)}) // R03 R04
        else $error("status read wrong");
    a_pkg_read: assert property (rd_hit && addr_reg == PSC_OFS_PKG |=>
        rsp.data == {10'h000, $past(pkg_type)}) // R07
        else $error("package type read wrong");
    a_diag_rsvd: assert property (rd_hit && addr_reg == PSC_OFS_DIAG |=>
        rsp.data[15:1] == 15'h0001 && rsp.data[0] == diag_clk_on) // R06 R15
        else $error("diagnostics register read wrong");
    a_group_write: assert property (req_valid && is_wr && dev_ok && grp_reg // R08
        && req.prtad == PSC_GROUP_PRTAD && addr_reg == PSC_OFS_PMG
        |=> boot_osc_force == $past(wbit))
        else $error("group write not taken");
    a_group_off: assert property (req_valid && is_wr && !grp_reg && req.prtad != my_prtad
        |=> $stable(boot_osc_force) && $stable(diag_clk_on) && $stable(pinmux_reg)) // R08
        else $error("foreign port write taken");
    a_pd_access: assert property (power_down_in && req_valid && is_rd // R14
        && dev_ok && own_port |=> rsp.valid)
        else $error("no answer during power-down");
    a_timer_rxd1: assert property (tm_sel == PSC_TM_RXD1 |=> rxd1_o == $past(timestamp_timer_out_src)) // R10
        else $error("timer not routed to rxd1");
    a_capt_none: assert property (capt_sel == PSC_TM_NONE |=> !capture_assigned) // R11
        else $error("capture assigned when unrouted");
    a_led1_off: assert property (led1_sel == PSC_L1_OFF |=> second_led_oe_n) // R12
        else $error("second led driven while disabled");
    a_link_pol: assert property (led1_sel == PSC_L1_LINK && capt_sel != PSC_CP_LED1
        |=> second_led_pin == link_status_out && !second_led_oe_n) // R12 R13
        else $error("link status on led pin wrong");

endmodule : psc_regs

`default_nettype wire

/* dv/psc_host.sv */
// management host model that issues operations to the register bank
`timescale 1ns/100ps
`default_nettype none

module psc_host
    import psc_pkg::*;
(
    // clock
    input wire logic clk,
    // request and answer
    output var logic req_valid,
    output var psc_req_s req,
    input wire psc_rsp_s rsp
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // one operation; the answer stands in the cycle after the taking edge
    task automatic xfer(input psc_op_e op, input logic [4:0] pa, input logic [4:0] da,
                        input logic [15:0] d, output logic v, output logic [15:0] q);
        @(posedge clk);
        #2;
        req_valid = 1'b1;
        req = '{op: op, prtad: pa, devad: da, data: d};
        @(posedge clk);
        #2;
        req_valid = 1'b0;
        v = rsp.valid;
        q = rsp.data;
    endtask : xfer

    task automatic wr(input logic [4:0] pa, input logic [15:0] ofs, input logic [15:0] d);
        logic v;
        logic [15:0] q;
        xfer(PSC_OP_ADDR, pa, PSC_DEVAD, ofs, v, q);
        xfer(PSC_OP_WRITE, pa, PSC_DEVAD, d, v, q);
    endtask : wr

    task automatic rd(input logic [4:0] pa, input logic [15:0] ofs, output logic v,
                      output logic [15:0] q);
        xfer(PSC_OP_ADDR, pa, PSC_DEVAD, ofs, v, q);
        xfer(PSC_OP_READ, pa, PSC_DEVAD, 16'h0000, v, q);
    endtask : rd

    // broadcast write: group mode is on only around the broadcast itself
    task automatic grp_wr(input logic [4:0] pa, input logic [15:0] ofs, input logic [15:0] d);
        wr(pa, PSC_OFS_MDIO, 16'h0001);
        wr(PSC_GROUP_PRTAD, ofs, d);
        wr(pa, PSC_OFS_MDIO, 16'h0000);
    endtask : grp_wr
endmodule : psc_host

`default_nettype wire

/* dv/psc_regs_tb.sv */
// self-checking testbench for the phy system control register bank
`timescale 1ns/100ps
`default_nettype none

module psc_regs_tb
    import psc_pkg::*;
;
    localparam logic [4:0] MY = 5'h03;
    localparam logic [15:0] OFS_TAB [9] = '{PSC_OFS_PHY_RST, PSC_OFS_MAC_RST, PSC_OFS_STAT,
        PSC_OFS_PMG, PSC_OFS_DIAG, PSC_OFS_PKG, PSC_OFS_MDIO, PSC_OFS_PINMUX, 16'h8816};
    localparam logic [15:0] EXP_TAB [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0002, 16'h002a, 16'h0000, 16'h00fe, 16'h0000};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sys_ready_in = 1'b0;
    logic power_down_in = 1'b0;
    logic [1:0] rdone = 2'h0;
    logic timestamp_timer_out_src = 1'b0;
    logic rxd1_func = 1'b0;
    logic led0_func = 1'b0;
    logic int_func = 1'b0;
    logic [6:0] l1src = 7'h00;
    logic [2:0] cpin = 3'h0;
    wire logic req_valid;
    wire psc_req_s req;
    wire psc_rsp_s rsp;
    wire logic [1:0] rreq;
    wire logic boot_osc_force, diag_clk_on, group_addr_mode, rxd1_o, first_led_pin, int_o;
    wire logic second_led_pin, second_led_oe_n, link_status_out;
    wire logic timestamp_capture_in, capture_assigned;
    int miscompares = 0;
    int num_checks = 0;
    int i;
    logic v;
    logic [15:0] q;

    always #12.5 clk = ~clk;

    psc_host u_host (.clk(clk), .req_valid(req_valid), .req(req), .rsp(rsp));

    psc_regs u_dut (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .my_prtad(MY), .rsp(rsp),
        .sys_ready_in(sys_ready_in), .power_down_in(power_down_in),
        .phy_rst_done(rdone[0]), .mac_rst_done(rdone[1]), .pkg_type(6'h2a),
        .phy_rst_req(rreq[0]), .mac_rst_req(rreq[1]), .boot_osc_force(boot_osc_force),
        .diag_clk_on(diag_clk_on), .group_addr_mode(group_addr_mode),
        .timestamp_timer_out_src(timestamp_timer_out_src), .rxd1_func(rxd1_func), .led0_func(led0_func),
        .int_func(int_func), .led1_func(l1src[0]), .tx_er(l1src[1]), .tx_en(l1src[2]),
        .tx_clk(l1src[3]), .txd0(l1src[4]), .txd2(l1src[5]), .link_up(l1src[6]),
        .rxd1_o(rxd1_o), .first_led_pin(first_led_pin), .int_o(int_o),
        .second_led_pin(second_led_pin), .second_led_oe_n(second_led_oe_n),
        .link_status_out(link_status_out), .txd1_pin(cpin[0]), .second_led_in(cpin[1]),
        .mdio_in(cpin[2]), .timestamp_capture_in(timestamp_capture_in),
        .capture_assigned(capture_assigned));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkb

    task automatic rc(input logic [15:0] ofs, input logic [15:0] exp);
        logic rv;
        logic [15:0] rq;
        u_host.rd(MY, ofs, rv, rq);
        chkb(rv, 1'b1);
        chk(rq, exp);
    endtask : rc

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        test_done;
    end

    initial begin
        repeat (12) @(posedge clk);
        #2;
        rst = 1'b0;
        chkb(second_led_oe_n, 1'b1);
        for (i = 0; i < 9; i++) rc(OFS_TAB[i], EXP_TAB[i]);
        $display("test reset_values done");
        for (i = 0; i < 2; i++) begin
            u_host.wr(MY, PSC_OFS_PHY_RST + 16'(i), 16'hffff);
            chkb(rreq[i], 1'b1);
            rc(PSC_OFS_PHY_RST + 16'(i), 16'h0001);
            chkb(rreq[i], 1'b1);
            rdone[i] = 1'b1;
            @(posedge clk);
            #2;
            rdone[i] = 1'b0;
            chkb(rreq[i], 1'b0);
            rc(PSC_OFS_PHY_RST + 16'(i), 16'h0000);
        end
        $display("test managed_resets done");
        sys_ready_in = 1'b1;
        power_down_in = 1'b1;
        u_host.wr(MY, PSC_OFS_STAT, 16'h0000);
        rc(PSC_OFS_STAT, 16'h0003);
        u_host.wr(MY, PSC_OFS_PMG, 16'hffff);
        u_host.wr(MY, PSC_OFS_DIAG, 16'hffff);
        chkb(boot_osc_force, 1'b1);
        chkb(diag_clk_on, 1'b1);
        rc(PSC_OFS_PMG, 16'h0001);
        rc(PSC_OFS_DIAG, 16'h0003);
        power_down_in = 1'b0;
        rc(PSC_OFS_STAT, 16'h0001);
        u_host.xfer(PSC_OP_ADDR, MY, PSC_DEVAD, PSC_OFS_DIAG, v, q);
        u_host.xfer(PSC_OP_READ_INC, MY, PSC_DEVAD, 16'h0000, v, q);
        chk(q, 16'h0003);
        u_host.xfer(PSC_OP_READ, MY, PSC_DEVAD, 16'h0000, v, q);
        chkb(v, 1'b1);
        chk(q, 16'h0000);
        $display("test status_and_clocks done");
        u_host.xfer(PSC_OP_ADDR, MY, 5'h01, PSC_OFS_PMG, v, q);
        u_host.xfer(PSC_OP_WRITE, MY, 5'h01, 16'h0000, v, q);
        chkb(boot_osc_force, 1'b1);
        u_host.wr(PSC_GROUP_PRTAD, PSC_OFS_PMG, 16'h0000);
        chkb(boot_osc_force, 1'b1);
        u_host.grp_wr(MY, PSC_OFS_PMG, 16'h0000);
        chkb(boot_osc_force, 1'b0);
        chkb(group_addr_mode, 1'b0);
        $display("test group_address done");
        u_host.wr(MY, PSC_OFS_PINMUX, 16'hffff);
        rc(PSC_OFS_PINMUX, 16'h00ff);
        timestamp_timer_out_src = 1'b1;
        for (i = 0; i < 4; i++) begin
            u_host.wr(MY, PSC_OFS_PINMUX, {8'h00, i[1:0], 2'h3, 3'h7, 1'b0});
            @(posedge clk);
            #2;
            chkb(rxd1_o, i == 0);
            chkb(first_led_pin, i == 1);
            chkb(int_o, i == 2);
        end
        timestamp_timer_out_src = 1'b0;
        rxd1_func = 1'b1;
        led0_func = 1'b1;
        int_func = 1'b1;
        @(posedge clk);
        #2;
        chkb(rxd1_o, 1'b1);
        chkb(first_led_pin, 1'b1);
        chkb(int_o, 1'b1);
        for (i = 0; i < 8; i++) begin
            l1src = 7'h01 << i;
            u_host.wr(MY, PSC_OFS_PINMUX, {8'h00, 2'h3, 2'h3, i[2:0], 1'b0});
            @(posedge clk);
            #2;
            chkb(second_led_pin, i < 7);
            chkb(second_led_oe_n, i == 7);
            l1src = ~l1src;
            @(posedge clk);
            #2;
            chkb(second_led_pin, 1'b0);
        end
        l1src = 7'h40;
        u_host.wr(MY, PSC_OFS_PINMUX, 16'h00fd);
        @(posedge clk);
        #2;
        chkb(link_status_out, 1'b0);
        chkb(second_led_pin, 1'b0);
        l1src = 7'h00;
        @(posedge clk);
        #2;
        chkb(link_status_out, 1'b1);
        chkb(second_led_pin, 1'b1);
        for (i = 0; i < 4; i++) begin
            cpin = (i == 3) ? 3'h7 : 3'h1 << i;
            u_host.wr(MY, PSC_OFS_PINMUX, {8'h00, 2'h3, i[1:0], 3'h7, 1'b0});
            repeat (4) @(posedge clk);
            #2;
            chkb(timestamp_capture_in, i < 3);
            chkb(capture_assigned, i != 3);
        end
        $display("test pin_mux done");
        test_done;
    end
endmodule : psc_regs_tb

`default_nettype wire
